// ---- src/pam_pkg.sv ----
// Shared constants and carrier types for the autoneg management registers
package pam_pkg;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [4:0] ADDR_ID_HIGH = 5'h02;
    localparam logic [4:0] ADDR_ID_LOW = 5'h03;
    localparam logic [4:0] ADDR_ADV = 5'h04;
    localparam logic [4:0] ADDR_LPA = 5'h05;
    localparam logic [4:0] ADDR_EXP = 5'h06;
    localparam logic [4:0] ADDR_NPTX = 5'h07;
    localparam logic [4:0] ADDR_NPRX = 5'h08;
    localparam logic [4:0] ADDR_IAC = 5'h0D;
    localparam logic [4:0] ADDR_IWIN = 5'h0E;

    // ****************************************
    // Field layouts, write masks and reset values
    // ****************************************
    localparam logic [15:0] ADV_WR_MASK = 16'hAFFF;
    localparam logic [15:0] ADV_RST = 16'h01E1;
    localparam logic [15:0] LPA_MASK = 16'hEFFF;
    localparam logic [15:0] NPTX_WR_MASK = 16'hB7FF;
    localparam logic [15:0] NPTX_RST = 16'h2001;
    localparam int NPTX_TOGGLE = 11;
    localparam logic [15:0] IAC_WR_MASK = 16'hC01F;
    localparam logic [15:0] IAC_RST = 16'h0000;
    localparam int IAC_FN_LO = 14;
    localparam int EXP_PDF = 4;
    localparam int EXP_LPNP = 3;
    localparam int EXP_LNP = 2;
    localparam int EXP_PR = 1;
    localparam int EXP_LPAN = 0;
    localparam logic [15:0] RD_ZERO = 16'h0000;
    localparam logic [15:0] ADDR_STEP = 16'h0001;

    // ****************************************
    // Window function codes
    // ****************************************
    typedef enum logic [1:0] {
        FN_ADDR = 2'h0,
        FN_DATA = 2'h1,
        FN_INC_RW = 2'h2,
        FN_INC_W = 2'h3
    } pam_fn_e;

    // One management access, already decoded from the serial frame
    typedef struct packed {
        logic [4:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } pam_req_s;

    // One access toward the Clause 45 register space
    typedef struct packed {
        logic [4:0] dev;
        logic [15:0] reg_addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } pam_mmd_s;

endpackage : pam_pkg

// ---- src/pam_sticky.sv ----
// Latch-high flag that clears when its register is read
`timescale 1ns/1ps
module pam_sticky
    import pam_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_rst,
    input wire logic set,
    input wire logic clr,
    output logic q
);

    // Set beats a clear in the same cycle so no event is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr || sw_rst) begin
            q <= 1'b0;
        end
    end

    AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
        set |=> q) else $error("flag lost its set");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        q && !clr && !sw_rst |=> q) else $error("flag fell unread");

endmodule : pam_sticky

// ---- src/pam_ind_addr.sv ----
// Clause 45 register address holder with post increment
`timescale 1ns/1ps
module pam_ind_addr
    import pam_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_rst,
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic inc,
    output logic [15:0] addr
);

    // Load and increment never coincide: load is address mode only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr <= RD_ZERO;
        end else if (sw_rst) begin
            addr <= RD_ZERO;
        end else if (load) begin
            addr <= load_val;
        end else if (inc) begin
            addr <= addr + ADDR_STEP;
        end
    end

    AST_INC_ONE: assert property (@(posedge clk) disable iff (rst)
        inc && !load && !sw_rst |=> addr == $past(addr) + ADDR_STEP)
        else $error("address did not step by one");
    AST_LOAD: assert property (@(posedge clk) disable iff (rst)
        load && !sw_rst |=> addr == $past(load_val))
        else $error("address not loaded");

endmodule : pam_ind_addr

// ---- src/pam_regs.sv ----
// Autoneg, identifier and indirect-access management register group
`timescale 1ns/1ps

module pam_regs
    import pam_pkg::*;
#(
    // Identifier fields in register order; values are arbitrary
    parameter logic [21:0] ORG_ID = 22'h2A5A5A,
    parameter logic [5:0] MODEL_NUM = 6'h15,
    parameter logic [3:0] REV_NUM = 4'h3
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sw_rst,
    input wire logic page_main,
    input wire pam_req_s req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic lp_base_valid,
    input wire logic [15:0] lp_base_word,
    input wire logic lp_np_valid,
    input wire logic [15:0] lp_np_word,
    input wire logic page_rcvd,
    input wire logic par_det_fault,
    input wire logic lp_np_capable,
    input wire logic lp_an_capable,
    input wire logic tx_lcw_sent,
    input wire logic tx_lcw_toggle,
    output logic [15:0] local_base_page,
    output logic [15:0] local_next_page,
    output pam_mmd_s mmd,
    input wire logic [15:0] mmd_rdata
);

    // ****************************************
    // Storage
    // ****************************************
    logic [15:0] adv_r;
    logic [15:0] nptx_r;
    logic toggle_r;
    logic [15:0] lpa_r;
    logic [15:0] nprx_r;
    logic [15:0] iac_r;
    logic [15:0] id_high;
    logic [15:0] id_low;
    logic [15:0] exp_word;
    logic [15:0] nptx_word;
    logic [15:0] win_addr;
    logic [15:0] rd_nxt;
    logic pdf_q;
    logic pr_q;
    logic wr_ok;
    logic rd_ok;
    logic exp_read;
    logic win_data;
    logic win_load;
    logic win_inc;
    pam_fn_e fn;

    // ****************************************
    // Access qualification
    // ****************************************
    // Outside page zero the whole group stays silent
    assign wr_ok = req.wr && page_main;
    assign rd_ok = req.rd && !req.wr && page_main;
    assign exp_read = rd_ok && (req.addr == ADDR_EXP);
    assign fn = pam_fn_e'(iac_r[15:14]);
    assign win_data = (req.addr == ADDR_IWIN) && (fn != FN_ADDR);

    // Address mode write retargets; data modes step per function
    assign win_load = wr_ok && (req.addr == ADDR_IWIN) &&
        (fn == FN_ADDR);
    assign win_inc = win_data &&
        ((fn == FN_INC_RW && (wr_ok || rd_ok)) ||
         (fn == FN_INC_W && wr_ok));

    // ****************************************
    // Fixed identifier words
    // ****************************************
    assign id_high = ORG_ID[21:6];
    assign id_low = {ORG_ID[5:0], MODEL_NUM, REV_NUM};

    // ****************************************
    // Local advertisement
    // ****************************************
    // Only the writable bits take write data; 14 and 12 stay zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adv_r <= ADV_RST;
        end else if (sw_rst) begin
            adv_r <= ADV_RST;
        end else if (wr_ok && req.addr == ADDR_ADV) begin
            adv_r <= req.wdata & ADV_WR_MASK;
        end
    end

    // Base page goes to the arbitration logic as written
    assign local_base_page = adv_r;

    // ****************************************
    // Next page transmit
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nptx_r <= NPTX_RST;
        end else if (sw_rst) begin
            nptx_r <= NPTX_RST;
        end else if (wr_ok && req.addr == ADDR_NPTX) begin
            nptx_r <= req.wdata & NPTX_WR_MASK;
        end
    end

    // Toggle follows the complement of the word just sent
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toggle_r <= 1'b0;
        end else if (sw_rst) begin
            toggle_r <= 1'b0;
        end else if (tx_lcw_sent) begin
            toggle_r <= !tx_lcw_toggle;
        end
    end

    always_comb begin
        nptx_word = nptx_r;
        nptx_word[NPTX_TOGGLE] = toggle_r;
    end

    assign local_next_page = nptx_word;

    // ****************************************
    // Partner pages
    // ****************************************
    // Reserved bit 12 of the base page is dropped on capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lpa_r <= RD_ZERO;
        end else if (sw_rst) begin
            lpa_r <= RD_ZERO;
        end else if (lp_base_valid) begin
            lpa_r <= lp_base_word & LPA_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nprx_r <= RD_ZERO;
        end else if (sw_rst) begin
            nprx_r <= RD_ZERO;
        end else if (lp_np_valid) begin
            nprx_r <= lp_np_word;
        end
    end

    // ****************************************
    // Expansion status
    // ****************************************
    pam_sticky u_pdf (
        .clk(clk),
        .rst(rst),
        .sw_rst(sw_rst),
        .set(par_det_fault),
        .clr(exp_read),
        .q(pdf_q)
    );

    pam_sticky u_pr (
        .clk(clk),
        .rst(rst),
        .sw_rst(sw_rst),
        .set(page_rcvd),
        .clr(exp_read),
        .q(pr_q)
    );

    // Bits 15:5 read zero; local next page ability is fixed
    always_comb begin
        exp_word = RD_ZERO;
        exp_word[EXP_PDF] = pdf_q;
        exp_word[EXP_LPNP] = lp_np_capable;
        exp_word[EXP_LNP] = 1'b1;
        exp_word[EXP_PR] = pr_q;
        exp_word[EXP_LPAN] = lp_an_capable;
    end

    // ****************************************
    // Indirect access control and window
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            iac_r <= IAC_RST;
        end else if (sw_rst) begin
            iac_r <= IAC_RST;
        end else if (wr_ok && req.addr == ADDR_IAC) begin
            iac_r <= req.wdata & IAC_WR_MASK;
        end
    end

    pam_ind_addr u_win (
        .clk(clk),
        .rst(rst),
        .sw_rst(sw_rst),
        .load(win_load),
        .load_val(req.wdata),
        .inc(win_inc),
        .addr(win_addr)
    );

    // Strobes are registered so the far side sees the address in use
    // before any increment lands
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mmd <= '0;
        end else begin
            mmd.dev <= iac_r[4:0];
            mmd.reg_addr <= win_addr;
            mmd.wr <= wr_ok && win_data;
            mmd.rd <= rd_ok && win_data;
            mmd.wdata <= req.wdata;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Unlisted addresses answer with zero
    always_comb begin
        case (req.addr)
            ADDR_ID_HIGH: rd_nxt = id_high;
            ADDR_ID_LOW: rd_nxt = id_low;
            ADDR_ADV: rd_nxt = adv_r;
            ADDR_LPA: rd_nxt = lpa_r;
            ADDR_EXP: rd_nxt = exp_word;
            ADDR_NPTX: rd_nxt = nptx_word;
            ADDR_NPRX: rd_nxt = nprx_r;
            ADDR_IAC: rd_nxt = iac_r;
            ADDR_IWIN: rd_nxt = (fn == FN_ADDR) ? win_addr : mmd_rdata;
            default: rd_nxt = RD_ZERO;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= RD_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= rd_ok;
            if (rd_ok) begin
                reg_rdata <= rd_nxt;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_rd(logic [4:0] a);
        rd_ok && req.addr == a;
    endsequence

    sequence s_wr(logic [4:0] a);
        wr_ok && req.addr == a && !sw_rst;
    endsequence

    AST_ID_HIGH: assert property (
        s_rd(ADDR_ID_HIGH) |=> reg_rvalid && reg_rdata == ORG_ID[21:6])
        else $error("identifier word one wrong");
    AST_ID_LOW: assert property (
        s_rd(ADDR_ID_LOW) |=> reg_rdata == {ORG_ID[5:0], MODEL_NUM,
        REV_NUM})
        else $error("identifier word two wrong");
    AST_ADV_RSVD: assert property (
        s_wr(ADDR_ADV) ##1 (!wr_ok && !sw_rst) ##1 s_rd(ADDR_ADV) |=>
        reg_rdata == ($past(req.wdata, 3) & ADV_WR_MASK))
        else $error("advertisement write-back wrong");
    AST_ADV_SWRST: assert property (
        sw_rst |=> local_base_page == ADV_RST)
        else $error("advertisement default lost");
    AST_PAGE_GATE: assert property (
        req.wr && !page_main && !sw_rst |=> $stable(adv_r) &&
        $stable(iac_r) && $stable(nptx_r))
        else $error("write taken outside page zero");
    AST_NO_RVALID: assert property (
        !page_main |=> !reg_rvalid)
        else $error("answer given outside page zero");
    AST_EXP_CLR: assert property (
        s_rd(ADDR_EXP) ##0 (!page_rcvd && !sw_rst) ##1 !page_rcvd
        |=> !pr_q)
        else $error("page received not cleared by read");
    AST_LNP_ONE: assert property (
        s_rd(ADDR_EXP) |=> reg_rdata[EXP_LNP] && reg_rdata[15:5] == '0)
        else $error("expansion constant bits wrong");
    AST_TOGGLE: assert property (
        tx_lcw_sent && !sw_rst |=> local_next_page[NPTX_TOGGLE] ==
        !$past(tx_lcw_toggle))
        else $error("toggle not complemented");
    AST_NPRX_CAP: assert property (
        lp_np_valid && !sw_rst ##1 (!lp_np_valid && !sw_rst) ##1
        s_rd(ADDR_NPRX) ##0 !lp_np_valid
        |=> reg_rdata == $past(lp_np_word, 3))
        else $error("partner next page not captured");
    AST_IAC_RSVD: assert property (
        s_rd(ADDR_IAC) |=> reg_rdata[13:5] == '0)
        else $error("control reserved bits not zero");
    AST_ADDR_NO_INC: assert property (
        fn == FN_ADDR |-> !win_inc)
        else $error("address mode stepped the address");
    AST_INC_W_ONLY: assert property (
        fn == FN_INC_W && rd_ok && req.addr == ADDR_IWIN |-> !win_inc)
        else $error("write-only increment stepped on read");

endmodule : pam_regs

// ---- verif/pam_mgmt_model.sv ----
// Station manager model issuing decoded register accesses
`timescale 1ns/1ps
module pam_mgmt_model
    import pam_pkg::*;
(
    input wire logic clk,
    output logic page_main,
    output pam_req_s req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    // Idle on the main page with no access pending
    initial begin
        page_main = 1'b1;
        req = '{addr: 5'h1F, wr: 1'b0, rd: 1'b0, wdata: 16'hFFFF};
    end

    // Page select only moves between accesses
    task automatic set_page(input logic p);
        @(posedge clk);
        #1;
        page_main <= p;
    endtask : set_page

    // Request held over the taking edge, then idle lines show inverted
    // content so a stale address or data value is never trusted
    task automatic xfer(input logic [4:0] a, input logic w,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic v);
        @(posedge clk);
        #1;
        req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk);
        #1;
        // Valid is a one-cycle pulse launched by the taking edge
        q = reg_rdata;
        v = reg_rvalid;
        req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask : xfer
endmodule : pam_mgmt_model

// ---- verif/tb.sv ----
// Self-checking bench for the autoneg management register group
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    begin \
        checks++; \
        if ((gt) !== (ex)) begin \
            num_errors++; \
            $display("unexpected %s exp %h got %h", nm, ex, gt); \
        end \
    end
module tb
    import pam_pkg::*;
;
    localparam logic [21:0] OID = 22'h13579B; // Arbitrary value
    localparam logic [5:0] MDL = 6'h2C; // Arbitrary value
    localparam logic [3:0] REV = 4'h9; // Arbitrary value
    logic clk, rst, sw_rst, page_main, reg_rvalid, v, tg, pdf, pr;
    logic lp_base_valid, lp_np_valid, page_rcvd, par_det_fault;
    logic lp_np_capable, lp_an_capable, tx_lcw_sent, tx_lcw_toggle;
    logic [15:0] reg_rdata, lp_base_word, lp_np_word, mmd_rdata;
    logic [15:0] local_base_page, local_next_page, q, w, ea;
    logic [4:0] dv;
    pam_req_s req;
    pam_mmd_s mmd;
    int num_errors, checks;

    pam_regs #(.ORG_ID(OID), .MODEL_NUM(MDL), .REV_NUM(REV)) pam_regs_inst (
        .clk(clk), .rst(rst), .sw_rst(sw_rst), .page_main(page_main),
        .req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .lp_base_valid(lp_base_valid), .lp_base_word(lp_base_word),
        .lp_np_valid(lp_np_valid), .lp_np_word(lp_np_word),
        .page_rcvd(page_rcvd), .par_det_fault(par_det_fault),
        .lp_np_capable(lp_np_capable), .lp_an_capable(lp_an_capable),
        .tx_lcw_sent(tx_lcw_sent), .tx_lcw_toggle(tx_lcw_toggle),
        .local_base_page(local_base_page),
        .local_next_page(local_next_page), .mmd(mmd),
        .mmd_rdata(mmd_rdata));

    pam_mgmt_model pam_mgmt_model_inst (.clk(clk), .page_main(page_main),
        .req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // Free-running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ****************************************
    // Expectations and bus helpers
    // ****************************************
    function automatic logic [15:0] exp_fn(input logic f, input logic p);
        return {11'h000, f, lp_np_capable, 1'b1, p, lp_an_capable};
    endfunction : exp_fn

    function automatic logic [15:0] npt_fn(input logic [15:0] d,
                                           input logic t);
        return (d & 16'hB7FF) | {4'h0, t, 11'h000};
    endfunction : npt_fn

    task automatic rd(input logic [4:0] a, input logic [15:0] ex,
                      input string nm);
        pam_mgmt_model_inst.xfer(a, 1'b0, 16'h0000, q, v);
        `CHK(nm, 1'b1, v)
        `CHK(nm, ex, q)
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        pam_mgmt_model_inst.xfer(a, 1'b1, d, q, v);
    endtask : wr

    // Order: base valid, next-page valid, page received, fault, sent
    task automatic side_pulse(input logic [4:0] s);
        @(posedge clk);
        #1;
        {lp_base_valid, lp_np_valid, page_rcvd, par_det_fault,
            tx_lcw_sent} = s;
        @(posedge clk);
        #1;
        {lp_base_valid, lp_np_valid, page_rcvd, par_det_fault,
            tx_lcw_sent} = 5'h00;
    endtask : side_pulse

    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Hang guard, bounded well above the run length
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("unexpected timeout exp %h got %h", 1'b0, 1'b1);
        final_report();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        num_errors = 0;
        checks = 0;
        void'($urandom(16));
        rst = 1'b1;
        {sw_rst, lp_base_valid, lp_np_valid, page_rcvd} = 4'h0;
        {par_det_fault, tx_lcw_sent, tx_lcw_toggle} = 3'h0;
        {lp_np_capable, lp_an_capable} = 2'b10;
        {lp_base_word, lp_np_word, mmd_rdata} = '0;
        tg = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK("base page", 16'h01E1, local_base_page)
        `CHK("next page", 16'h2001, local_next_page)
        rd(ADDR_LPA, 16'h0000, "lpa");
        rd(ADDR_EXP, exp_fn(1'b0, 1'b0), "exp");
        rd(ADDR_NPTX, 16'h2001, "nptx");
        rd(ADDR_NPRX, 16'h0000, "nprx");
        rd(ADDR_IAC, 16'h0000, "iac");
        rd(5'h0A, 16'h0000, "unmapped");
        // Random words, all ones first to hit every read-only bit
        for (int i = 0; i < 5; i++) begin
            w = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(ADDR_ID_HIGH, w);
            wr(ADDR_ID_LOW, w);
            rd(ADDR_ID_HIGH, OID[21:6], "id high");
            rd(ADDR_ID_LOW, {OID[5:0], MDL, REV}, "id low");
            wr(ADDR_ADV, w);
            rd(ADDR_ADV, w & 16'hAFFF, "adv");
            `CHK("base page", w & 16'hAFFF, local_base_page)
            wr(ADDR_NPTX, w);
            rd(ADDR_NPTX, npt_fn(w, tg), "nptx");
            wr(ADDR_LPA, ~w);
            wr(ADDR_NPRX, ~w);
            lp_base_word = 16'($urandom);
            lp_np_word = (i == 0) ? 16'hFFFF : 16'($urandom);
            side_pulse(5'b11000);
            rd(ADDR_NPRX, lp_np_word, "nprx");
            rd(ADDR_LPA, lp_base_word & 16'hEFFF, "lpa");
            tx_lcw_toggle = 1'($urandom);
            side_pulse(5'b00001);
            tg = ~tx_lcw_toggle;
            rd(ADDR_NPTX, npt_fn(w, tg), "toggle");
            `CHK("np toggle", tg, local_next_page[11])
            {pdf, pr} = 2'($urandom);
            {lp_np_capable, lp_an_capable} = 2'($urandom);
            side_pulse({2'b00, pr, pdf, 1'b0});
            rd(ADDR_EXP, exp_fn(pdf, pr), "exp");
            rd(ADDR_EXP, exp_fn(1'b0, 1'b0), "exp clr");
        end
        // Accesses while another page is selected are ignored
        pam_mgmt_model_inst.set_page(1'b0);
        wr(ADDR_ADV, 16'h0000);
        pam_mgmt_model_inst.xfer(ADDR_ADV, 1'b0, 16'h0000, q, v);
        `CHK("gated read", 1'b0, v)
        pam_mgmt_model_inst.set_page(1'b1);
        rd(ADDR_ADV, w & 16'hAFFF, "gated write");
        // Device address first, then address mode, then each data mode
        dv = 5'($urandom);
        wr(ADDR_IAC, {2'b00, 9'h1FF, dv});
        ea = 16'($urandom);
        wr(ADDR_IWIN, ea);
        `CHK("no access", 1'b0, mmd.wr)
        rd(ADDR_IWIN, ea, "win addr");
        for (int f = 1; f < 4; f++) begin
            wr(ADDR_IAC, {2'(f), 9'h1FF, dv});
            rd(ADDR_IAC, {2'(f), 9'h000, dv}, "iac");
            w = 16'($urandom);
            wr(ADDR_IWIN, w);
            `CHK("mmd wr", pam_mmd_s'({dv, ea, 2'b10, w}), mmd)
            if (f > 1) ea++;
            mmd_rdata = 16'($urandom);
            rd(ADDR_IWIN, mmd_rdata, "win data");
            `CHK("mmd rd", {dv, ea, 2'b01}, mmd[38:16])
            mmd_rdata = ~mmd_rdata;
            if (f == 2) ea++;
        end
        wr(ADDR_IAC, {2'b00, 9'h000, dv});
        rd(ADDR_IWIN, ea, "win addr");
        rd(ADDR_IWIN, ea, "win addr");
        // Software reset restores defaults and drops pending flags
        side_pulse(5'b00110);
        @(posedge clk);
        #1;
        sw_rst = 1'b1;
        @(posedge clk);
        #1;
        sw_rst = 1'b0;
        rd(ADDR_ADV, 16'h01E1, "adv");
        rd(ADDR_EXP, exp_fn(1'b0, 1'b0), "exp");
        rd(ADDR_IAC, 16'h0000, "iac");
        final_report();
    end
endmodule : tb
